// ---- hw/cpo_pkg.sv ----
// Package for the counter pulse output and sync block.
// Assumes a single 125 MHz clock domain and an APB master on the register port.
package cpo_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses, one aligned word each)
	// ----------------------------------------------------------------
	localparam logic [7:0] CPO_ADDR_CTRL   = 8'h00;
	localparam logic [7:0] CPO_ADDR_PERIOD = 8'h04;
	localparam logic [7:0] CPO_ADDR_HIGH   = 8'h08;
	localparam logic [7:0] CPO_ADDR_NPULSE = 8'h0C;
	localparam logic [7:0] CPO_ADDR_STATUS = 8'h10;
	localparam logic [7:0] CPO_ADDR_COUNT  = 8'h14;
	localparam logic [7:0] CPO_ADDR_SYNC   = 8'h18;
	localparam logic [7:0] CPO_ADDR_CARDID = 8'h1C;

	// ----------------------------------------------------------------
	// Control fields
	// ----------------------------------------------------------------
	localparam int CPO_CTRL_START  = 0;
	localparam int CPO_CTRL_STOP   = 1;
	localparam int CPO_CTRL_MODE_L = 2;
	localparam int CPO_CTRL_CNTEN  = 4;
	localparam int CPO_CTRL_CNTCLR = 5;
	localparam int CPO_SYNC_MASTER = 8;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] CPO_PERIOD_RST = 32'h0000_0002;
	localparam logic [31:0] CPO_HIGH_RST   = 32'h0000_0001;
	localparam logic [31:0] CPO_NPULSE_RST = 32'h0000_0001;

	typedef enum logic [1:0] {
		CPO_MODE_SINGLE,
		CPO_MODE_FINITE,
		CPO_MODE_CONT,
		CPO_MODE_RSVD
	} cpo_mode_t;

	typedef enum {CPO_IDLE, CPO_HIGH, CPO_LOW} cpo_state_t;

endpackage

// ---- hw/cpo_counter_pulse_output_sync.sv ----
// Counter pulse output, two-pulse up/down counter, board sync port and card id.
// Assumes all pins are synchronous to clk and the APB master follows APB rules.
// How it works
// - Single mode sends one pulse per start and then rests idle.
// - Pulse width is duty share of the period, both set as timebase counts.
// - Finite mode sends exactly the programmed number of pulses (one for a count of zero) and stops.
// - Continuous mode repeats pulses until software writes stop.
// - A rising edge on input A raises the count by one unless B rises in the same cycle.
// - A rising edge on input B lowers the count by one unless A rises in the same cycle, in any mode.
// - Up to four boards share the sync port, exactly one set as master.
// - Eight trigger lines each are driven or received per board role.
// - A card number from a switch is readable by software.
// - While counting is enabled, count rises on each rising edge of A and falls on each rising edge of B, unless both rise in the same cycle.
module cpo_counter_pulse_output_sync
	import cpo_pkg::*;
#(
	parameter int CNT_W = 32,
	parameter int ID_W  = 4
) (
	input  wire logic              clk,
	input  wire logic              nrst,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	output logic                   counter_pulse_out,
	input  wire logic              count_input_a,
	input  wire logic              count_input_b,
	input  wire logic [7:0]        board_sync_port_in,
	output logic      [7:0]        board_sync_port_out,
	output logic      [7:0]        board_sync_port_oe,
	input  wire logic [ID_W-1:0]   card_id_switch
);

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic [CNT_W-1:0] period_ff, nxt_period;
	logic [CNT_W-1:0] high_ff, nxt_high;
	logic [CNT_W-1:0] npulse_ff, nxt_npulse;
	logic [1:0]       mode_ff, nxt_mode;
	logic             cnten_ff, nxt_cnten;
	logic             master_ff, nxt_master;
	logic [7:0]       sync_drv_ff, nxt_sync_drv;
	logic [ID_W-1:0]  card_id_ff, nxt_card_id;
	logic [31:0]      prdata_ff, nxt_prdata;
	logic             slverr_ff, nxt_slverr;
	logic             rd_wait_ff, nxt_rd_wait;

	logic wr_en;
	logic rd_en;
	logic start_pulse;
	logic stop_pulse;
	logic clr_pulse;
	logic wr_unmapped;

	// Writes finish in one access cycle; a read waits one cycle so prdata comes from a flop.
	assign wr_en       = psel && penable && pwrite;
	assign rd_en       = psel && penable && !pwrite && !rd_wait_ff;
	assign wr_unmapped = !(paddr inside {CPO_ADDR_CTRL, CPO_ADDR_PERIOD, CPO_ADDR_HIGH,
		CPO_ADDR_NPULSE, CPO_ADDR_STATUS, CPO_ADDR_COUNT, CPO_ADDR_SYNC, CPO_ADDR_CARDID});
	assign start_pulse = wr_en && (paddr == CPO_ADDR_CTRL) && pwdata[CPO_CTRL_START];
	assign stop_pulse  = wr_en && (paddr == CPO_ADDR_CTRL) && pwdata[CPO_CTRL_STOP];
	assign clr_pulse   = wr_en && (paddr == CPO_ADDR_CTRL) && pwdata[CPO_CTRL_CNTCLR];
	assign pready      = !rd_en; // Low only in the first access cycle of a read.
	assign prdata      = prdata_ff;
	assign pslverr     = slverr_ff || (wr_en && wr_unmapped);

	// ----------------------------------------------------------------
	// Pulse generator state
	// ----------------------------------------------------------------
	cpo_state_t       st_ff, nxt_st;
	logic [CNT_W-1:0] tick_ff, nxt_tick;
	logic [CNT_W-1:0] left_ff, nxt_left;
	logic             out_ff, nxt_out;

	// ----------------------------------------------------------------
	// Up/down counter state
	// ----------------------------------------------------------------
	logic [CNT_W-1:0] count_ff, nxt_count;
	logic             a_d_ff, nxt_a_d;
	logic             b_d_ff, nxt_b_d;

	// Register writes, read data and the card number capture.
	always_comb begin
		nxt_period   = period_ff;
		nxt_high     = high_ff;
		nxt_npulse   = npulse_ff;
		nxt_mode     = mode_ff;
		nxt_cnten    = cnten_ff;
		nxt_master   = master_ff;
		nxt_sync_drv = sync_drv_ff;
		nxt_card_id  = card_id_switch;
		nxt_prdata   = prdata_ff;
		nxt_slverr   = 1'b0;
		nxt_rd_wait  = rd_en;
		if (wr_en) begin
			unique case (paddr)
				CPO_ADDR_CTRL: begin
					nxt_mode  = pwdata[CPO_CTRL_MODE_L +: 2];
					nxt_cnten = pwdata[CPO_CTRL_CNTEN];
				end
				CPO_ADDR_PERIOD: nxt_period = pwdata[CNT_W-1:0];
				CPO_ADDR_HIGH:   nxt_high   = pwdata[CNT_W-1:0];
				CPO_ADDR_NPULSE: nxt_npulse = pwdata[CNT_W-1:0];
				CPO_ADDR_SYNC: begin
					nxt_sync_drv = pwdata[7:0];
					nxt_master   = pwdata[CPO_SYNC_MASTER];
				end
				CPO_ADDR_STATUS, CPO_ADDR_COUNT, CPO_ADDR_CARDID: ;
				default: ; // Unmapped writes are refused through pslverr.
			endcase
		end
		if (rd_en) begin
			unique case (paddr)
				CPO_ADDR_CTRL:   nxt_prdata = {26'h0, 1'b0, cnten_ff, mode_ff, 2'h0};
				CPO_ADDR_PERIOD: nxt_prdata = 32'(period_ff);
				CPO_ADDR_HIGH:   nxt_prdata = 32'(high_ff);
				CPO_ADDR_NPULSE: nxt_prdata = 32'(npulse_ff);
				CPO_ADDR_STATUS: nxt_prdata = {30'h0, out_ff, (st_ff != CPO_IDLE)};
				CPO_ADDR_COUNT:  nxt_prdata = 32'(count_ff);
				CPO_ADDR_SYNC:   nxt_prdata = {15'h0, master_ff, board_sync_port_in,
					sync_drv_ff};
				CPO_ADDR_CARDID: nxt_prdata = 32'(card_id_ff);
				default: begin
					nxt_prdata = 32'h0000_0000;
					nxt_slverr = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			period_ff   <= CNT_W'(CPO_PERIOD_RST);
			high_ff     <= CNT_W'(CPO_HIGH_RST);
			npulse_ff   <= CNT_W'(CPO_NPULSE_RST);
			mode_ff     <= 2'h0;
			cnten_ff    <= 1'b0;
			master_ff   <= 1'b0;
			sync_drv_ff <= 8'h00;
			card_id_ff  <= '0;
			prdata_ff   <= 32'h0000_0000;
			slverr_ff   <= 1'b0;
			rd_wait_ff  <= 1'b0;
		end else begin
			period_ff   <= nxt_period;
			high_ff     <= nxt_high;
			npulse_ff   <= nxt_npulse;
			mode_ff     <= nxt_mode;
			cnten_ff    <= nxt_cnten;
			master_ff   <= nxt_master;
			sync_drv_ff <= nxt_sync_drv;
			card_id_ff  <= nxt_card_id;
			prdata_ff   <= nxt_prdata;
			slverr_ff   <= nxt_slverr;
			rd_wait_ff  <= nxt_rd_wait;
		end
	end

	// Pulse sequencer: high phase then low phase, repeated per mode.
	// A period or high count of zero is treated as one so the output never hangs.
	always_comb begin
		nxt_st   = st_ff;
		nxt_tick = tick_ff;
		nxt_left = left_ff;
		nxt_out  = out_ff;
		unique case (st_ff)
			CPO_IDLE: begin
				nxt_out = 1'b0;
				if (start_pulse && pwdata[CPO_CTRL_MODE_L +: 2] != CPO_MODE_RSVD) begin
					nxt_st   = CPO_HIGH;
					nxt_out  = 1'b1;
					nxt_tick = '0;
					nxt_left = (pwdata[CPO_CTRL_MODE_L +: 2] == CPO_MODE_FINITE) ?
						npulse_ff : CNT_W'(1);
				end
			end
			CPO_HIGH: begin
				nxt_tick = tick_ff + CNT_W'(1);
				if (tick_ff + CNT_W'(1) >= high_ff) begin
					nxt_st  = CPO_LOW;
					nxt_out = 1'b0;
				end
			end
			CPO_LOW: begin
				nxt_tick = tick_ff + CNT_W'(1);
				if (tick_ff + CNT_W'(1) >= period_ff) begin
					nxt_tick = '0;
					if (mode_ff == CPO_MODE_CONT) begin
						nxt_st  = CPO_HIGH;
						nxt_out = 1'b1;
					end else if (left_ff > CNT_W'(1)) begin
						nxt_left = left_ff - CNT_W'(1);
						nxt_st   = CPO_HIGH;
						nxt_out  = 1'b1;
					end else begin
						nxt_st = CPO_IDLE;
					end
				end
			end
		endcase
		if (stop_pulse) begin
			nxt_st  = CPO_IDLE;
			nxt_out = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_ff   <= CPO_IDLE;
			tick_ff <= '0;
			left_ff <= '0;
			out_ff  <= 1'b0;
		end else begin
			st_ff   <= nxt_st;
			tick_ff <= nxt_tick;
			left_ff <= nxt_left;
			out_ff  <= nxt_out;
		end
	end

	assign counter_pulse_out = out_ff;

	// Two-pulse counter: edge on A counts up, edge on B counts down.
	// Simultaneous edges cancel, which keeps the count honest.
	always_comb begin
		nxt_a_d   = count_input_a;
		nxt_b_d   = count_input_b;
		nxt_count = count_ff;
		if (cnten_ff) begin
			if (count_input_a && !a_d_ff && !(count_input_b && !b_d_ff))
				nxt_count = count_ff + CNT_W'(1);
			else if (count_input_b && !b_d_ff && !(count_input_a && !a_d_ff))
				nxt_count = count_ff - CNT_W'(1);
		end
		if (clr_pulse)
			nxt_count = '0;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			count_ff <= '0;
			a_d_ff   <= 1'b0;
			b_d_ff   <= 1'b0;
		end else begin
			count_ff <= nxt_count;
			a_d_ff   <= nxt_a_d;
			b_d_ff   <= nxt_b_d;
		end
	end

	// Sync lines: the master drives the lines software selects; slaves only listen.
	assign board_sync_port_out = sync_drv_ff;
	assign board_sync_port_oe  = master_ff ? sync_drv_ff : 8'h00;

endmodule

// ---- verification/cpo_chk_asserts.sv ----
// Checker for the pulse output and sync block.
// Assumes it is bound to the top module and sees its ports only.
module cpo_chk
	import cpo_pkg::*;
#(
	parameter int ID_W = 4
) (
	input wire logic		clk,
	input wire logic		nrst,
	input wire logic		psel,
	input wire logic		penable,
	input wire logic		pwrite,
	input wire logic		pready,
	input wire logic [7:0]		paddr,
	input wire logic [31:0]		pwdata,
	input wire logic [31:0]		prdata,
	input wire logic		counter_pulse_out,
	input wire logic [7:0]		board_sync_port_out,
	input wire logic [7:0]		board_sync_port_oe,
	input wire logic [ID_W-1:0]	card_id_switch
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----
	// Shadow state
	// ----
	logic [31:0]	hi_ff, pe_ff, hr_ff, lr_ff, nxt_hi, nxt_pe, nxt_hr, nxt_lr;
	logic [1:0]	md_ff, nxt_md;
	wire		o = counter_pulse_out;
	wire		wr = psel & penable & pwrite;
	wire		stp = wr && paddr == CPO_ADDR_CTRL && pwdata[CPO_CTRL_STOP];
	// Mirror timing writes so run lengths can be judged without seeing the body.
	always_comb begin
		nxt_hi = wr && paddr == CPO_ADDR_HIGH ? pwdata : hi_ff;
		nxt_pe = wr && paddr == CPO_ADDR_PERIOD ? pwdata : pe_ff;
		nxt_md = wr && paddr == CPO_ADDR_CTRL && pwdata[0] ? pwdata[3:2] : md_ff;
		nxt_hr = o ? hr_ff + 32'h1 : 32'h0;
		nxt_lr = o ? 32'h0 : lr_ff + 32'h1;
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			{hi_ff, pe_ff, hr_ff, lr_ff} <= {CPO_HIGH_RST, CPO_PERIOD_RST, 64'h0};
			md_ff <= 2'h0;
		end else begin
			{hi_ff, pe_ff, hr_ff, lr_ff} <= {nxt_hi, nxt_pe, nxt_hr, nxt_lr};
			md_ff <= nxt_md;
		end
	end
	// ----
	// Properties
	// ----
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	chk_high_time: assert property ($fell(o) && !$past(stp) |-> hr_ff == hi_ff)
		else $error("high time wrong");
	// Long idle gaps are skipped; only gaps inside a train are judged.
	chk_low_time: assert property ($rose(o) && lr_ff < pe_ff |-> lr_ff == pe_ff - hi_ff)
		else $error("low time wrong");
	chk_single_once: assert property ($fell(o) && md_ff == 2'h0 |=> !o [*8])
		else $error("single pulse repeated");
	chk_stop_low: assert property (stp |=> !o)
		else $error("output high after stop");
	chk_reset_idle: assert property ($rose(nrst) |-> !o)
		else $error("output high after reset");
	chk_sync_role: assert property (board_sync_port_oe == 8'h00 ||
		board_sync_port_oe == board_sync_port_out)
		else $error("sync enable wrong");
	chk_sync_hold: assert property (!$past(wr && paddr == CPO_ADDR_SYNC) |->
		$stable(board_sync_port_out))
		else $error("sync lines moved");
	// Read data must stand at the edge that completes the read.
	chk_card_id: assert property (psel && penable && !pwrite && pready &&
		paddr == CPO_ADDR_CARDID |-> prdata[ID_W-1:0] == $past(card_id_switch, 2))
		else $error("card id wrong");
	cover property ($fell(o) && md_ff == 2'h1);
	cover property (stp && o);
	cover property (board_sync_port_oe != 8'h00);
endmodule

bind cpo_counter_pulse_output_sync cpo_chk #(.ID_W(ID_W)) u_cpo_chk (.*);

// ---- verification/cpo_peer.sv ----
// Peer boards and wiring on the eight trigger lines.
// Assumes the bench says which lines the peers drive.
module cpo_peer (
	input wire logic	clk,
	input wire logic [7:0]	drv,
	input wire logic [7:0]	oe,
	input wire logic [7:0]	pdrv,
	input wire logic [7:0]	poe,
	output logic [7:0]	line
);
	timeunit 1ns;
	timeprecision 1ps;
	logic tog_ff = 1'b0;
	// An undriven line has no pull, so it wanders instead of keeping a value.
	always @(posedge clk) tog_ff <= ~tog_ff;
	assign line = oe & drv | ~oe & poe & pdrv | ~oe & ~poe & {8{tog_ff}};
endmodule

// ---- verification/cpo_counter_pulse_output_sync_tb_top.sv ----
// Self-checking bench for the pulse output and sync block.
// Assumes the package, design, checker and peer are compiled first.
module cpo_counter_pulse_output_sync_tb_top
	import cpo_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic		clk, nrst, psel, penable, pwrite, pready, pslverr, rerr;
	logic		count_input_a, count_input_b, counter_pulse_out;
	logic [7:0]	paddr, board_sync_port_in, board_sync_port_out, board_sync_port_oe;
	logic [7:0]	pdrv, poe, eo;
	logic [31:0]	pwdata, prdata, rdat;
	logic [3:0]	card_id_switch;
	int		n_fail, n_tests, p, h, k, n, r, hs;
	cpo_counter_pulse_output_sync u_cpo_counter_pulse_output_sync (.*);
	cpo_peer u_cpo_peer (.clk, .drv(board_sync_port_out), .oe(board_sync_port_oe), .pdrv,
		.poe, .line(board_sync_port_in));
	always #4 clk = ~clk;
	// ----
	// Tasks
	// ----
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			n_fail++;
			$display("[ERR] %0t %h %h", $time, s, e);
		end
	endtask
	// One APB transfer; an idle edge first keeps drives one per time step.
	// Read data and the error flag are taken at the edge that sees pready high.
	task automatic xf(input bit w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	// The slave may stall a read; xf waits for it and keeps the answer.
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		xf(0, a, 32'h0);
		chk(rdat, e);
	endtask
	task automatic pulse(input bit b);
		@(posedge clk);
		{count_input_b, count_input_a} <= b ? 2'b10 : 2'b01;
		@(posedge clk);
		{count_input_b, count_input_a} <= 2'b00;
		repeat (2) @(posedge clk);
	endtask
	// Count high cycles and rising edges over a window.
	task automatic meas(input int c);
		bit pv;
		{r, hs, pv} = '0;
		repeat (c) begin
			@(negedge clk);
			if (counter_pulse_out === 1'b1) begin
				hs++;
				r += !pv;
			end
			pv = counter_pulse_out === 1'b1;
		end
		@(posedge clk);
	endtask
	task automatic tally_and_finish;
		if (n_fail == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		#100000;
		n_fail++;
		tally_and_finish();
	end
	// ----
	// Main sequence
	// ----
	initial begin
		clk = 1'b0;
		{nrst, psel, penable, pwrite, count_input_a, count_input_b} = '0;
		{paddr, pwdata, pdrv, poe} = '0;
		void'($urandom(55));
		card_id_switch = 4'($urandom);
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		rd(CPO_ADDR_CARDID, 32'(card_id_switch));
		rd(8'h20, 32'h0);
		chk(32'(rerr), 32'h1);
		xf(1, CPO_ADDR_CTRL, 32'h30);
		xf(1, CPO_ADDR_CTRL, 32'h10);
		n = 3 + $urandom % 5;
		repeat (n) pulse(0);
		rd(CPO_ADDR_COUNT, 32'(n));
		xf(1, CPO_ADDR_CTRL, 32'h14);
		rd(CPO_ADDR_CTRL, 32'h14);
		repeat (n + 2) pulse(1);
		rd(CPO_ADDR_COUNT, 32'hFFFF_FFFE);
		p = 4 + $urandom % 6;
		h = 1 + $urandom % (p - 1);
		k = 2 + $urandom % 3;
		xf(1, CPO_ADDR_PERIOD, 32'(p));
		xf(1, CPO_ADDR_HIGH, 32'(h));
		xf(1, CPO_ADDR_NPULSE, 32'(k));
		for (int m = 0; m < 3; m++) begin
			xf(1, CPO_ADDR_CTRL, 32'(m * 4 + 1));
			meas(m == 0 ? 3 * p : m == 1 ? (k + 2) * p : 4 * p);
			n = m == 0 ? 1 : m == 1 ? k : 4;
			chk(32'(r), 32'(n));
			chk(32'(hs), 32'(n * h));
		end
		xf(1, CPO_ADDR_CTRL, 32'h2);
		meas(2 * p);
		chk(32'(hs), 32'h0);
		xf(1, CPO_ADDR_CTRL, 32'hD);
		meas(2 * p);
		chk(32'(hs), 32'h0);
		for (int s = 0; s < 2; s++) begin
			@(posedge clk);
			n = $urandom % 256;
			eo = s ? 8'(n) : 8'h00;
			pdrv <= 8'($urandom);
			poe <= ~eo;
			xf(1, CPO_ADDR_SYNC, 32'(s * 256 + n));
			repeat (4) @(posedge clk);
			chk(32'(board_sync_port_oe), 32'(eo));
			rd(CPO_ADDR_SYNC, {15'h0, s[0], eo & 8'(n) | ~eo & pdrv, 8'(n)});
		end
		tally_and_finish();
	end
endmodule
